/* File: rtl/sac_pkg.sv */
package sac_pkg;
	// ----------------------------------------
	// Geometry
	// ----------------------------------------
	localparam int RES_BITS = 16;
	localparam int CLK_PERIOD_PS = 8000;
	// ----------------------------------------
	// Timing, printed figures and derived counts
	// ----------------------------------------
	localparam int POR_WAIT_NS = 20000;
	localparam int CONV_MAX_NS = 3000;
	localparam int ACQ_START_NS = 527;
	localparam int RETRIG_WIN_NS = 40;
	// Longest time rounds down, least time rounds up
	localparam int CONV_CYC = (CONV_MAX_NS * 1000) / CLK_PERIOD_PS;
	localparam int ACQ_CYC = (ACQ_START_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int POR_CYC = (POR_WAIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int CNT_W = 12;
	localparam logic [15:0] RESULT_RST = 16'h0000;
	// ----------------------------------------
	// Host command/status register map (AXI4-Lite, byte addresses)
	// ----------------------------------------
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STAT = 4'h4;
	localparam logic [3:0] REG_DATA = 4'h8;
	localparam logic [3:0] REG_DIV = 4'hc;
	localparam int CTRL_START = 0;
	localparam int CTRL_CHAIN = 1;
	localparam int CTRL_SEL = 2;
	localparam int STAT_BUSY = 0;
	localparam int STAT_READY = 1;
	localparam int STAT_VALID = 2;
	localparam logic [7:0] DIV_RST = 8'h04;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : sac_pkg

/* File: rtl/sac_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface sac_if;
	logic conversion_trigger;
	logic busy;
	logic sck;
	logic sdo_o;
	logic sdo_oe;
	logic read_select_or_cascade_input;
	logic chain_mode;
	modport dev (
		input conversion_trigger,
		input sck,
		input read_select_or_cascade_input,
		input chain_mode,
		output busy,
		output sdo_o,
		output sdo_oe
	);
	modport host (
		output conversion_trigger,
		output sck,
		output read_select_or_cascade_input,
		output chain_mode,
		input busy,
		input sdo_o,
		input sdo_oe
	);
endinterface : sac_if
`default_nettype wire

/* File: rtl/sac_dev.sv */
`timescale 1ns/1ps
`default_nettype none
module sac_dev #(
	parameter int CONV_CYCLES = sac_pkg::CONV_CYC,
	parameter int ACQ_CYCLES = sac_pkg::ACQ_CYC
) (
	input wire logic aclk,
	input wire logic aresetn,
	sac_if.dev link,
	input wire logic [sac_pkg::RES_BITS-1:0] sample_code,
	output logic acquiring,
	output logic powered_down
);
	import sac_pkg::*;

	initial begin
		if (CONV_CYCLES < 2 || CONV_CYCLES >= (1 << CNT_W) || ACQ_CYCLES >= CONV_CYCLES)
			$error("sac_dev: bad cycle counts");
	end

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [1:0] trig_s_q, sck_s_q, rsel_s_q, chain_s_q;
	logic trig_last_q, sck_last_q;
	always_ff @(posedge aclk) begin
		trig_s_q <= {trig_s_q[0], link.conversion_trigger};
		sck_s_q <= {sck_s_q[0], link.sck};
		rsel_s_q <= {rsel_s_q[0], link.read_select_or_cascade_input};
		chain_s_q <= {chain_s_q[0], link.chain_mode};
		trig_last_q <= trig_s_q[1];
		sck_last_q <= sck_s_q[1];
	end
	wire trig_rise = trig_s_q[1] & ~trig_last_q;
	wire sck_rise = sck_s_q[1] & ~sck_last_q;
	wire rsel = rsel_s_q[1];
	wire chain = chain_s_q[1];

	// ----------------------------------------
	// Conversion sequencer
	// ----------------------------------------
	typedef enum logic [0:0] {
		SAC_SLEEP = 1'b0,
		SAC_CONV = 1'b1
	} sac_state_t;
	sac_state_t state_q;
	logic [CNT_W-1:0] cnt_q;
	logic [RES_BITS-1:0] shreg_q;
	logic busy_q, acq_q, sdo_q, oe_q, pd_q;
	wire conv_done = (state_q == SAC_CONV) && (cnt_q == CNT_W'(CONV_CYCLES - 1));
	// A new trigger edge only counts while asleep
	wire start = (state_q == SAC_SLEEP) && trig_rise;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= SAC_SLEEP;
			cnt_q <= '0;
			busy_q <= 1'b0;
			acq_q <= 1'b1;
			pd_q <= 1'b1;
		end else begin
			case (state_q)
				SAC_SLEEP: begin
					if (start) begin
						state_q <= SAC_CONV;
						cnt_q <= '0;
						busy_q <= 1'b1;
						acq_q <= 1'b0;
						pd_q <= 1'b0;
					end
				end
				SAC_CONV: begin
					cnt_q <= cnt_q + 1'b1;
					if (cnt_q == CNT_W'(ACQ_CYCLES - 1))
						acq_q <= 1'b1;
					if (conv_done) begin
						state_q <= SAC_SLEEP;
						busy_q <= 1'b0;
						pd_q <= 1'b1;
					end
				end
				default: state_q <= SAC_SLEEP;
			endcase
		end
	end

	// ----------------------------------------
	// Output shifter
	// ----------------------------------------
	// Loading at the same edge BUSY falls puts the MSB out with it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			shreg_q <= RESULT_RST;
			sdo_q <= 1'b0;
		end else if (conv_done) begin
			shreg_q <= sample_code;
			sdo_q <= sample_code[RES_BITS-1];
		end else if (sck_rise && (chain || !rsel)) begin
			// Cascade feeds the serial input in; normal mode shifts zeros
			shreg_q <= {shreg_q[RES_BITS-2:0], chain & rsel};
			sdo_q <= shreg_q[RES_BITS-2];
		end else if (!chain && rsel) begin
			// Keep SDO on the shift register's top bit so the next select-low shows that bit at once
			sdo_q <= shreg_q[RES_BITS-1];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			oe_q <= 1'b0;
		else
			oe_q <= chain | ~rsel;
	end

	assign link.busy = busy_q;
	assign link.sdo_o = sdo_q;
	assign link.sdo_oe = oe_q;
	assign acquiring = acq_q;
	assign powered_down = pd_q;
endmodule : sac_dev
`default_nettype wire

/* File: rtl/sac_host.sv */
// Design decisions made here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module sac_host #(
	parameter int POR_CYCLES = sac_pkg::POR_CYC
) (
	input wire logic aclk,
	input wire logic aresetn,
	sac_if.host link,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import sac_pkg::*;

	initial begin
		if (POR_CYCLES < 1 || POR_CYCLES > 65535)
			$error("sac_host: bad POR_CYCLES");
	end

	// ----------------------------------------
	// Sync of device pins
	// ----------------------------------------
	logic [1:0] busy_s_q, sdo_s_q;
	logic busy_last_q;
	always_ff @(posedge aclk) begin
		busy_s_q <= {busy_s_q[0], link.busy};
		sdo_s_q <= {sdo_s_q[0], link.sdo_o};
		busy_last_q <= busy_s_q[1];
	end
	wire busy_fall = ~busy_s_q[1] & busy_last_q;

	// ----------------------------------------
	// Registers and AXI4-Lite slave
	// ----------------------------------------
	logic chain_q, sel_q, valid_q, por_ok_q, start_q;
	logic [7:0] div_q;
	logic [15:0] por_cnt_q, data_q;
	logic aw_q, w_q;
	logic [3:0] awaddr_q;
	logic [31:0] wdata_q;
	wire do_write = aw_q & w_q & ~s_axi_bvalid;
	wire wr_ctrl = do_write && awaddr_q == REG_CTRL;
	wire wr_div = do_write && awaddr_q == REG_DIV;
	wire wr_ok = wr_ctrl | wr_div;
	typedef enum logic [1:0] {
		SAC_H_IDLE = 2'b00,
		SAC_H_CONV = 2'b01,
		SAC_H_READ = 2'b10
	} sac_hstate_t;
	sac_hstate_t hst_q;
	wire ready = por_ok_q && hst_q == SAC_H_IDLE;
	wire [31:0] stat_w = {29'h0, valid_q, ready, hst_q != SAC_H_IDLE};
	wire [31:0] rd_w = (s_axi_araddr == REG_CTRL) ? {29'h0, sel_q, chain_q, 1'b0} :
		(s_axi_araddr == REG_STAT) ? stat_w :
		(s_axi_araddr == REG_DATA) ? {16'h0, data_q} :
		(s_axi_araddr == REG_DIV) ? {24'h0, div_q} : 32'h0;
	wire rd_ok = s_axi_araddr[1:0] == 2'b00;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_q <= 1'b0;
			w_q <= 1'b0;
			awaddr_q <= 4'h0;
			wdata_q <= 32'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_q <= 1'b1;
				wdata_q <= s_axi_wdata;
			end
			if (do_write) begin
				aw_q <= 1'b0;
				w_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_w;
				s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end
	assign s_axi_awready = ~aw_q & ~s_axi_bvalid;
	assign s_axi_wready = ~w_q & ~s_axi_bvalid;
	assign s_axi_arready = ~s_axi_rvalid;

	// ----------------------------------------
	// Conversion and readout engine
	// ----------------------------------------
	logic [7:0] div_cnt_q;
	logic [4:0] bit_q;
	logic trig_q, sck_q, rsel_q, chain_o_q;
	wire tick = div_cnt_q == 8'h00;
	// Start is refused until the settle wait ends
	wire go = wr_ctrl && wdata_q[CTRL_START] && ready;
	// Read sample lands one tick after a rising SCK, before the SDO change it causes is through both syncs (div_q below 6)
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			por_cnt_q <= 16'h0;
			por_ok_q <= 1'b0;
			chain_q <= 1'b0;
			sel_q <= 1'b0;
			div_q <= DIV_RST;
			div_cnt_q <= 8'h0;
			hst_q <= SAC_H_IDLE;
			valid_q <= 1'b0;
			data_q <= 16'h0;
			bit_q <= 5'h0;
			trig_q <= 1'b0;
			sck_q <= 1'b0;
			rsel_q <= 1'b1;
		end else begin
			if (!por_ok_q) begin
				por_cnt_q <= por_cnt_q + 16'h1;
				por_ok_q <= por_cnt_q == 16'(POR_CYCLES - 1);
			end
			if (wr_ctrl) begin
				chain_q <= wdata_q[CTRL_CHAIN];
				sel_q <= wdata_q[CTRL_SEL];
			end
			if (wr_div)
				div_q <= (wdata_q[7:0] == 8'h0) ? 8'h1 : wdata_q[7:0];
			div_cnt_q <= tick ? div_q - 8'h1 : div_cnt_q - 8'h1;
			case (hst_q)
				SAC_H_IDLE: begin
					rsel_q <= ~chain_q & ~sel_q;
					if (go) begin
						trig_q <= 1'b1;
						valid_q <= 1'b0;
						hst_q <= SAC_H_CONV;
					end
				end
				SAC_H_CONV: begin
					if (busy_fall) begin
						trig_q <= 1'b0;
						rsel_q <= 1'b0;
						bit_q <= 5'h0;
						hst_q <= SAC_H_READ;
					end
				end
				SAC_H_READ: begin
					if (tick) begin
						sck_q <= ~sck_q;
						if (sck_q) begin
							data_q <= {data_q[14:0], sdo_s_q[1]};
							bit_q <= bit_q + 5'h1;
							if (bit_q == 5'd15) begin
								valid_q <= 1'b1;
								rsel_q <= 1'b1;
								hst_q <= SAC_H_IDLE;
							end
						end
					end
				end
				default: hst_q <= SAC_H_IDLE;
			endcase
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn)
			chain_o_q <= 1'b0;
		else
			chain_o_q <= chain_q;
	end

	assign link.conversion_trigger = trig_q;
	assign link.sck = sck_q;
	assign link.read_select_or_cascade_input = rsel_q;
	assign link.chain_mode = chain_o_q;
endmodule : sac_host
`default_nettype wire

/* File: dv/sac_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module sac_properties #(
	parameter int CONV_CYCLES = 375
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic conversion_trigger,
	input wire logic busy,
	input wire logic sck,
	input wire logic sdo_o,
	input wire logic sdo_oe,
	input wire logic read_select_or_cascade_input,
	input wire logic chain_mode
);
	// ----
	// Busy length counter
	// ----
	logic [11:0] cnt_q;
	logic [11:0] cnt_d;
	assign cnt_d = busy ? cnt_q + 12'h001 : 12'h000;
	always_ff @(posedge aclk) begin
		cnt_q <= aresetn ? cnt_d : 12'h000;
	end
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Stray trigger edges must not stretch or repeat the conversion
	sequence conv_end;
		##[0:375] $fell(busy) ##1 !busy [*4];
	endsequence
	sequence link_quiet;
		(!busy && $stable(sck) && $stable(read_select_or_cascade_input)
			&& $stable(chain_mode)) [*6];
	endsequence
	chk_busy_start: assert property ($rose(conversion_trigger) && !busy |-> ##[2:5] $rose(busy))
		else $error("busy did not follow trigger");
	chk_no_restart: assert property (busy && $rose(conversion_trigger) |=> conv_end)
		else $error("conversion restarted");
	chk_busy_len: assert property ($fell(busy) |-> cnt_q == 12'(CONV_CYCLES))
		else $error("busy length wrong");
	chk_busy_min: assert property ($rose(busy) |-> busy [*8])
		else $error("busy dropped early");
	chk_float_high: assert property ((!chain_mode && read_select_or_cascade_input) [*6] |-> !sdo_oe)
		else $error("sdo driven while deselected");
	chk_drive_low: assert property ((!chain_mode && !read_select_or_cascade_input) [*6] |-> sdo_oe)
		else $error("sdo not driven while selected");
	chk_chain_drive: assert property (chain_mode [*6] |-> sdo_oe)
		else $error("sdo not driven in cascade");
	chk_sdo_hold: assert property (link_quiet |-> $stable(sdo_o))
		else $error("sdo moved without sck");
	chk_por_wait: assert property ($rose(aresetn) |-> !conversion_trigger [*8])
		else $error("trigger before start-up wait");
endmodule : sac_properties
`default_nettype wire

/* File: dv/sac_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module sac_tb_top;
	import sac_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [15:0] code = 16'h0000;
	logic [3:0] awa = 4'h0;
	logic [3:0] ara = 4'h0;
	logic [31:0] wd = 32'h0;
	logic awv = 1'b0;
	logic wv = 1'b0;
	logic arv = 1'b0;
	logic brdy = 1'b0;
	logic rrdy = 1'b0;
	logic awr, wr, arr, bv, rv;
	logic [1:0] br, rr;
	logic [31:0] rd, q;
	logic [1:0] r;
	logic pdn, acq;
	int err_total = 0;
	int tests_run = 0;
	sac_if link ();
	sac_dev #(.CONV_CYCLES(CONV_CYC), .ACQ_CYCLES(ACQ_CYC)) sac_dev_inst (.aclk(aclk),
		.aresetn(aresetn), .link(link), .sample_code(code), .acquiring(acq), .powered_down(pdn));
	sac_host #(.POR_CYCLES(8)) sac_host_inst (.aclk(aclk), .aresetn(aresetn), .link(link),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br),
		.s_axi_bvalid(bv), .s_axi_bready(brdy), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
		.s_axi_rready(rrdy));
	sac_properties #(.CONV_CYCLES(CONV_CYC)) sac_properties_inst (.aclk(aclk),
		.aresetn(aresetn), .conversion_trigger(link.conversion_trigger), .busy(link.busy),
		.sck(link.sck), .sdo_o(link.sdo_o), .sdo_oe(link.sdo_oe), .chain_mode(link.chain_mode),
		.read_select_or_cascade_input(link.read_select_or_cascade_input));
	initial begin
		forever #4 aclk = ~aclk;
	end
	// ----
	// Expectations and bus cycles
	// ----
	function automatic logic [31:0] ctrl(input logic st, input logic ch, input logic sl);
		return {29'h0, sl, ch, st};
	endfunction : ctrl
	function automatic logic [31:0] exp_data(input logic [15:0] c);
		return {16'h0000, c};
	endfunction : exp_data
	task conclude;
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : conclude
	task cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
		tests_run++;
		if (s !== e) begin
			$display("unexpected %s exp %h got %h", nm, e, s);
			err_total++;
		end
	endtask : cmp
	task tmo;
		err_total++;
		$display("unexpected wait exp done got hang");
		conclude();
	endtask : tmo
	// Readies are looked at mid-cycle, where they already hold what the next edge samples
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		logic ha, hw, hr, hb;
		n = 0;
		hb = 1'b0;
		@(posedge aclk);
		if (w) begin
			awa <= a;
			wd <= d;
			awv <= 1'b1;
			wv <= 1'b1;
			brdy <= 1'b1;
		end else begin
			ara <= a;
			arv <= 1'b1;
			rrdy <= 1'b1;
		end
		while (!hb) begin
			@(negedge aclk);
			ha = awv && awr;
			hw = wv && wr;
			hr = arv && arr;
			hb = w ? bv : rv;
			q = rd;
			r = w ? br : rr;
			@(posedge aclk);
			if (ha) awv <= 1'b0;
			if (hw) wv <= 1'b0;
			if (hr) arv <= 1'b0;
			n++;
			if (n > 100) tmo();
		end
		brdy <= 1'b0;
		rrdy <= 1'b0;
	endtask : bus
	task wait_stat(input logic [2:0] m, input logic [2:0] v);
		int n;
		n = 0;
		q = 32'h0;
		while ((q[2:0] & m) !== v) begin
			bus(1'b0, REG_STAT, 32'h0);
			n++;
			if (n > 300) tmo();
		end
	endtask : wait_stat
	// ----
	// Main sequence
	// ----
	initial begin
		void'($urandom(32'h707e34c3));
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		bus(1'b1, REG_CTRL, ctrl(1'b1, 1'b0, 1'b0));
		bus(1'b0, REG_STAT, 32'h0);
		cmp("early busy", 32'h0, q[STAT_BUSY]);
		bus(1'b0, REG_DIV, 32'h0);
		cmp("div reset", {24'h0, DIV_RST}, q);
		bus(1'b0, 4'h2, 32'h0);
		cmp("misaligned resp", RESP_SLVERR, r);
		bus(1'b1, REG_STAT, 32'h0);
		cmp("stat write resp", RESP_SLVERR, r);
		bus(1'b1, REG_DIV, 32'h2);
		cmp("div write resp", RESP_OKAY, r);
		$display("test registers done");
		for (int i = 0; i < 8; i++) begin
			code <= (i == 0) ? 16'h0000 : (i == 1) ? 16'hffff : (i == 2) ? 16'h8000 : 16'($urandom);
			bus(1'b1, REG_CTRL, ctrl(1'b1, i[0], 1'b0));
			wait_stat(3'b001, 3'b001);
			if (i == 2) bus(1'b1, REG_CTRL, ctrl(1'b1, 1'b0, 1'b0));
			wait_stat(3'b001, 3'b000);
			wait_stat(3'b110, 3'b110);
			bus(1'b0, REG_DATA, 32'h0);
			cmp("result", exp_data(code), q);
			cmp("data resp", RESP_OKAY, r);
			$display("test conversion %0d done", i);
		end
		bus(1'b1, REG_CTRL, ctrl(1'b0, 1'b0, 1'b1));
		repeat (20) @(posedge aclk);
		bus(1'b0, REG_STAT, 32'h0);
		cmp("idle busy", 32'h0, q[STAT_BUSY]);
		cmp("select low enable", 32'h1, {31'h0, link.sdo_oe});
		cmp("idle powered down", 32'h1, {31'h0, pdn});
		cmp("idle acquiring", 32'h1, {31'h0, acq});
		bus(1'b1, REG_CTRL, ctrl(1'b0, 1'b0, 1'b0));
		repeat (20) @(posedge aclk);
		cmp("select high enable", 32'h0, {31'h0, link.sdo_oe});
		$display("test deselect done");
		conclude();
	end
endmodule : sac_tb_top
`default_nettype wire
